/* File: logic/link_if.sv */
// the two link wires between programmer and sensor
`timescale 1ns/1ps
interface link_if;
  logic supply_line;
  logic out_line;
  modport programmer (output supply_line, input out_line);
  modport sensor     (input supply_line, output out_line);
endinterface

/* File: logic/link_pkg.sv */
// types shared by both ends of the programming link
`include "link_regs.svh"
package link_pkg;
  typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_BIT  = 2'h2} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} tx_state_t;
  typedef enum logic [2:0] {MODE_BOOT = 3'h1, MODE_PROG = 3'h2, MODE_APP = 3'h4} mode_t;

  typedef struct packed {
    rx_state_t                 rx_st;
    logic [1:0]                sync;
    logic                      prev;
    logic [`LINK_CNT_W-1:0]    rx_cnt;
    logic                      mid;
    logic [`LINK_WORD_W-1:0]   rx_sh;
    logic [4:0]                rx_n;
    logic                      done;
    logic                      err;
    tx_state_t                 tx_st;
    logic                      line;
    logic [`LINK_CNT_W-1:0]    tx_cnt;
    logic [`LINK_WORD_W-1:0]   tx_sh;
    logic [4:0]                tx_n;
  } codec_state_t;

  typedef struct packed {
    mode_t                     mode;
    logic [1:0]                boot_cnt;
    logic [1:0]                seal_sync;
    logic                      sealed;
    logic                      app_bit;
    logic                      seal_prog;
    logic [4:0]                tc_lin;
    logic [4:0]                tc_quad;
    logic [7:0]                err_cnt;
  } dev_state_t;

  typedef struct packed {
    logic [`LINK_WORD_W-1:0]   reply;
    logic [2:0]                stat;
    logic [2:0]                mask;
    logic                      was_busy;
    logic [`LINK_WORD_W-1:0]   rdata;
  } host_state_t;
endpackage

/* File: logic/link_regs.svh */
// constants of the supply-modulated programming link
//
// Operation
// - power-up enters programming mode unless sealed
// - app bit or seal selects application mode
// - programmer sends telegrams on supply line
// - sensor answers by modulating its output
// - zero: no transition inside bit period
// - one: transition at half bit period
// - transition at end of every bit
// - programmer bit period 1024 us
// - sensor answer bit period 1024 us
// - telegrams carry memory, errors, field values
// - written seal takes effect next power-up
// - programmer sets seal after final programming
// - programmer reads seal back to confirm
// - diagnostic register must read all zero
// - temperature codes from magnet coefficient mapping
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

`define LINK_BIT_US      1024
`define LINK_CLK_MHZ     100
`define LINK_CNT_W       18
`define LINK_WORD_W      16
`define LINK_WORD_BITS   5'h10
`define LINK_BOOT_WAIT   2'h3

`define LINK_OP_MSB      15
`define LINK_OP_LSB      14
`define LINK_ADR_MSB     13
`define LINK_ADR_LSB     8
`define LINK_DAT_MSB     7
`define LINK_OP_READ     2'h0
`define LINK_OP_WRITE    2'h1
`define LINK_OP_REPLY    2'h2

`define DEV_CTRL         6'h00
`define DEV_DIAG         6'h01
`define DEV_TC_LIN       6'h02
`define DEV_TC_QUAD      6'h03
`define DEV_FIELD        6'h04
`define DEV_ERR          6'h05
`define DEV_CTRL_APP     0
`define DEV_CTRL_SEAL    1
`define DEV_TC_LIN_RST   5'h15
`define DEV_TC_QUAD_RST  5'h1b

`define HOST_CMD         4'h0
`define HOST_STATUS      4'h1
`define HOST_REPLY       4'h2
`define HOST_INT         4'h3
`define HOST_MASK        4'h4
`define HOST_INT_SENT    0
`define HOST_INT_REPLY   1
`define HOST_INT_ERR     2

`endif

/* File: logic/programmer_end.sv */
// programmer end of the programming link with register port
`timescale 1ns/1ps
`include "link_regs.svh"
module programmer_end #(
  parameter int BIT_CYCLES = `LINK_BIT_US * `LINK_CLK_MHZ
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  link_if.programmer                   link,
  input  wire logic [3:0]              addr,
  input  wire logic [`LINK_WORD_W-1:0] wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic [`LINK_WORD_W-1:0]      rdata,
  output logic                         irq
);
  link_pkg::host_state_t   r;
  link_pkg::host_state_t   next_r;
  logic                    tx_start;
  logic                    tx_busy;
  logic [`LINK_WORD_W-1:0] rx_word;
  logic                    rx_done;
  logic                    rx_err;

  // a command written while a telegram is going out is dropped
  assign tx_start = wr && addr == `HOST_CMD && !tx_busy;

  line_codec #(.BIT_CYCLES(BIT_CYCLES)) codec (
    .clk      (clk),
    .rst      (rst),
    .line_in  (link.out_line),
    .line_out (link.supply_line),
    .tx_start (tx_start),
    .tx_word  (wdata),
    .tx_busy  (tx_busy),
    .rx_word  (rx_word),
    .rx_done  (rx_done),
    .rx_err   (rx_err)
  );

  always_comb begin
    next_r          = r;
    next_r.rdata    = '0;
    next_r.was_busy = tx_busy;
    if (rd) begin
      case (addr)
        `HOST_STATUS: next_r.rdata = {15'h0000, tx_busy};
        // reply holds seal and diagnostic read-backs for software checks
        `HOST_REPLY:  next_r.rdata = r.reply;
        `HOST_INT: begin
          next_r.rdata = {13'h0000, r.stat};
          next_r.stat  = 3'h0;
        end
        `HOST_MASK:   next_r.rdata = {13'h0000, r.mask};
        default:      next_r.rdata = '0;
      endcase
    end
    if (wr && addr == `HOST_MASK)
      next_r.mask = wdata[2:0];
    // set wins over the read clear
    if (r.was_busy && !tx_busy)
      next_r.stat[`HOST_INT_SENT] = 1'b1;
    if (rx_done) begin
      next_r.reply                 = rx_word;
      next_r.stat[`HOST_INT_REPLY] = 1'b1;
    end
    if (rx_err)
      next_r.stat[`HOST_INT_ERR] = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign irq   = |(r.stat & r.mask);
endmodule // programmer_end

/* File: logic/sensor_end.sv */
// line codec and the sensor end of the programming link
`timescale 1ns/1ps
`include "link_regs.svh"
module line_codec #(
  parameter int BIT_CYCLES = `LINK_BIT_US * `LINK_CLK_MHZ
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    line_in,
  output logic                         line_out,
  input  wire logic                    tx_start,
  input  wire logic [`LINK_WORD_W-1:0] tx_word,
  output logic                         tx_busy,
  output logic [`LINK_WORD_W-1:0]      rx_word,
  output logic                         rx_done,
  output logic                         rx_err
);
  localparam logic [`LINK_CNT_W-1:0] T_HALF = `LINK_CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [`LINK_CNT_W-1:0] T_END  = `LINK_CNT_W'(BIT_CYCLES - 1);
  localparam logic [`LINK_CNT_W-1:0] T_Q1   = `LINK_CNT_W'(BIT_CYCLES / 4);
  localparam logic [`LINK_CNT_W-1:0] T_Q3   = `LINK_CNT_W'(BIT_CYCLES * 3 / 4);
  localparam logic [`LINK_CNT_W-1:0] T_Q5   = `LINK_CNT_W'(BIT_CYCLES * 5 / 4);

  // the counters cannot hold a bit period beyond their width
  if (BIT_CYCLES < 8 || BIT_CYCLES * 5 / 4 >= (1 << `LINK_CNT_W)) begin : g_bad_bit_cycles
    $error("line_codec: BIT_CYCLES out of range");
  end

  link_pkg::codec_state_t r;
  link_pkg::codec_state_t next_r;
  logic                   edge_seen;

  // only the second sync stage feeds the edge detector
  assign edge_seen = r.sync[1] != r.prev;

  always_comb begin
    next_r        = r;
    next_r.sync   = {r.sync[0], line_in};
    next_r.prev   = r.sync[1];
    next_r.done   = 1'b0;
    next_r.err    = 1'b0;
    case (r.rx_st)
      link_pkg::RX_IDLE: begin
        if (edge_seen) begin
          next_r.rx_st  = link_pkg::RX_BIT;
          next_r.rx_cnt = '0;
          next_r.mid    = 1'b0;
          next_r.rx_n   = '0;
        end
      end
      link_pkg::RX_BIT: begin
        next_r.rx_cnt = r.rx_cnt + 1'b1;
        if (edge_seen) begin
          if (r.rx_cnt < T_Q1) begin
            next_r.err   = 1'b1;
            next_r.rx_st = link_pkg::RX_IDLE;
          end else if (r.rx_cnt < T_Q3) begin
            // a second mid edge in one bit is a broken telegram
            if (r.mid) begin
              next_r.err   = 1'b1;
              next_r.rx_st = link_pkg::RX_IDLE;
            end else begin
              next_r.mid = 1'b1;
            end
          end else begin
            next_r.rx_sh  = {r.rx_sh[`LINK_WORD_W-2:0], r.mid};
            next_r.rx_cnt = '0;
            next_r.mid    = 1'b0;
            next_r.rx_n   = r.rx_n + 1'b1;
            if (r.rx_n == `LINK_WORD_BITS - 1'b1) begin
              next_r.done  = 1'b1;
              next_r.rx_st = link_pkg::RX_IDLE;
            end
          end
        end else if (r.rx_cnt > T_Q5) begin
          next_r.err   = 1'b1;
          next_r.rx_st = link_pkg::RX_IDLE;
        end
      end
      default: next_r.rx_st = link_pkg::RX_IDLE;
    endcase

    case (r.tx_st)
      link_pkg::TX_IDLE: begin
        if (tx_start) begin
          // opening edge marks the start of the first bit
          next_r.tx_st  = link_pkg::TX_SEND;
          next_r.line   = ~r.line;
          next_r.tx_cnt = '0;
          next_r.tx_sh  = tx_word;
          next_r.tx_n   = `LINK_WORD_BITS;
        end
      end
      link_pkg::TX_SEND: begin
        next_r.tx_cnt = r.tx_cnt + 1'b1;
        if (r.tx_cnt == T_HALF && r.tx_sh[`LINK_WORD_W-1])
          next_r.line = ~r.line;
        if (r.tx_cnt == T_END) begin
          next_r.line   = ~r.line;
          next_r.tx_sh  = {r.tx_sh[`LINK_WORD_W-2:0], 1'b0};
          next_r.tx_cnt = '0;
          next_r.tx_n   = r.tx_n - 1'b1;
          if (r.tx_n == 5'h01)
            next_r.tx_st = link_pkg::TX_IDLE;
        end
      end
      default: next_r.tx_st = link_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r       <= '0;
      r.rx_st <= link_pkg::RX_IDLE;
      r.tx_st <= link_pkg::TX_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign line_out = r.line;
  assign tx_busy  = r.tx_st != link_pkg::TX_IDLE;
  assign rx_word  = r.rx_sh;
  assign rx_done  = r.done;
  assign rx_err   = r.err;
endmodule // line_codec

module sensor_end #(
  parameter int BIT_CYCLES = `LINK_BIT_US * `LINK_CLK_MHZ
) (
  input  wire logic  clk,
  input  wire logic  rst,
  link_if.sensor     link,
  input  wire logic  sealed_nv,
  input  wire logic [7:0] diag_flags,
  input  wire logic [7:0] field_value,
  output logic       prog_mode,
  output logic       app_mode,
  output logic       seal_write,
  output logic [4:0] linear_temp_coefficient_code,
  output logic [4:0] quadratic_temp_coefficient_code
);
  link_pkg::dev_state_t    r;
  link_pkg::dev_state_t    next_r;
  logic                    tx_start;
  logic [`LINK_WORD_W-1:0] tx_word;
  logic [`LINK_WORD_W-1:0] rx_word;
  logic                    rx_done;
  logic                    rx_err;
  logic [1:0]              op;
  logic [5:0]              adr;
  logic [7:0]              dat;
  logic [7:0]              rd_val;

  line_codec #(.BIT_CYCLES(BIT_CYCLES)) codec (
    .clk      (clk),
    .rst      (rst),
    .line_in  (link.supply_line),
    .line_out (link.out_line),
    .tx_start (tx_start),
    .tx_word  (tx_word),
    .tx_busy  (),
    .rx_word  (rx_word),
    .rx_done  (rx_done),
    .rx_err   (rx_err)
  );

  assign op  = rx_word[`LINK_OP_MSB:`LINK_OP_LSB];
  assign adr = rx_word[`LINK_ADR_MSB:`LINK_ADR_LSB];
  assign dat = rx_word[`LINK_DAT_MSB:0];

  always_comb begin
    case (adr)
      `DEV_CTRL:    rd_val = {6'h00, r.seal_prog, r.app_bit};
      `DEV_DIAG:    rd_val = diag_flags;
      `DEV_TC_LIN:  rd_val = {3'h0, r.tc_lin};
      `DEV_TC_QUAD: rd_val = {3'h0, r.tc_quad};
      `DEV_FIELD:   rd_val = field_value;
      `DEV_ERR:     rd_val = r.err_cnt;
      default:      rd_val = 8'h00;
    endcase
  end

  always_comb begin
    next_r           = r;
    next_r.seal_sync = {r.seal_sync[0], sealed_nv};
    tx_start         = 1'b0;
    tx_word          = '0;
    case (r.mode)
      link_pkg::MODE_BOOT: begin
        // wait for the seal strap to clear its synchroniser
        next_r.boot_cnt = r.boot_cnt + 1'b1;
        if (r.boot_cnt == `LINK_BOOT_WAIT) begin
          next_r.sealed = r.seal_sync[1];
          next_r.mode   = r.seal_sync[1] ? link_pkg::MODE_APP
                                         : link_pkg::MODE_PROG;
        end
      end
      link_pkg::MODE_PROG: begin
        if (r.app_bit) begin
          next_r.mode = link_pkg::MODE_APP;
        end else if (rx_done) begin
          if (op == `LINK_OP_READ) begin
            tx_start = 1'b1;
            tx_word  = {`LINK_OP_REPLY, adr, rd_val};
          end else if (op == `LINK_OP_WRITE) begin
            tx_start = 1'b1;
            tx_word  = {`LINK_OP_REPLY, adr, dat};
            case (adr)
              `DEV_CTRL: begin
                next_r.app_bit   = dat[`DEV_CTRL_APP];
                // stored seal only acts after the next power-up
                next_r.seal_prog = dat[`DEV_CTRL_SEAL];
              end
              `DEV_TC_LIN:  next_r.tc_lin  = dat[4:0];
              `DEV_TC_QUAD: next_r.tc_quad = dat[4:0];
              default: ;
            endcase
          end else if (r.err_cnt != 8'hff) begin
            next_r.err_cnt = r.err_cnt + 1'b1;
          end
        end else if (rx_err && r.err_cnt != 8'hff) begin
          next_r.err_cnt = r.err_cnt + 1'b1;
        end
      end
      // application mode is left only by power-up
      link_pkg::MODE_APP: ;
      default: next_r.mode = link_pkg::MODE_BOOT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r         <= '0;
      r.mode    <= link_pkg::MODE_BOOT;
      r.tc_lin  <= `DEV_TC_LIN_RST;
      r.tc_quad <= `DEV_TC_QUAD_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prog_mode                       = r.mode == link_pkg::MODE_PROG;
  assign app_mode                        = r.mode == link_pkg::MODE_APP;
  assign seal_write                      = r.seal_prog;
  assign linear_temp_coefficient_code    = r.tc_lin;
  assign quadratic_temp_coefficient_code = r.tc_quad;
endmodule // sensor_end

/* File: sim/link_sva.sv */
// assertions on the link wires and the sensor mode outputs
`timescale 1ns/1ps
module link_sva #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_line,
  input wire logic out_line,
  input wire logic prog_mode,
  input wire logic app_mode,
  input wire logic sealed_nv
);
  localparam int HALF  = BIT_CYCLES / 2;
  localparam int FRAME = 16 * BIT_CYCLES;
  logic [1:0] prev;
  logic [1:0] tgl;
  logic [1:0] act;
  int         t [2];
  // frame time counts from an edge on an idle line; idle value saturates past the frame
  assign tgl = {out_line, supply_line} ^ prev;
  assign act = {t[1] <= FRAME, t[0] <= FRAME};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 2'h0;
      t <= '{FRAME + 64, FRAME + 64};
    end else begin
      prev <= {out_line, supply_line};
      for (int i = 0; i < 2; i++) begin
        if (tgl[i] && !act[i]) t[i] <= 1;
        else if (t[i] < FRAME + 64) t[i] <= t[i] + 1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_boot_wait;
    (!prog_mode && !app_mode) [*2];
  endsequence
  sequence s_mode_set;
    (prog_mode || app_mode) && app_mode == sealed_nv;
  endsequence
  a_boot_mode: assert property ($fell(rst) |-> s_boot_wait ##[2:4] s_mode_set)
    else $error("mode after reset does not follow seal state");
  a_mode_excl: assert property (!(prog_mode && app_mode))
    else $error("both modes active");
  a_app_sticky: assert property (app_mode |=> app_mode)
    else $error("application mode left without reset");
  a_sup_grid: assert property (tgl[0] && act[0] |-> t[0] % HALF == 0)
    else $error("supply edge off the half bit grid");
  a_sup_bound: assert property (act[0] && t[0] % BIT_CYCLES == 0 |-> tgl[0])
    else $error("supply bit boundary without edge");
  a_out_grid: assert property (tgl[1] && act[1] |-> t[1] % HALF == 0)
    else $error("answer edge off the half bit grid");
  a_out_bound: assert property (act[1] && t[1] % BIT_CYCLES == 0 |-> tgl[1])
    else $error("answer bit boundary without edge");
  a_reply_slot: assert property (tgl[1] && !act[1] |->
    t[0] > FRAME && t[0] <= FRAME + 8 && $past(prog_mode, 8))
    else $error("answer not right after a command in programming mode");
endmodule // link_sva

/* File: sim/testbench.sv */
// self-checking bench: programmer and sensor joined by the link
`timescale 1ns/1ps
`include "link_regs.svh"
module testbench;
  localparam int BIT = 16;
  logic        clk = 1'b0;
  logic        rst, sealed_nv, wr, rd, irq, prog_mode, app_mode, seal_write;
  logic [7:0]  diag_flags, field_value;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, got;
  logic [4:0]  lin_code, quad_code;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  // magnet coefficient table, quadratic codes in two's complement
  logic [4:0]  lin_tab [15] = '{8, 10, 12, 14, 16, 18, 20, 21, 22, 23, 24, 25, 27, 29, 31};
  logic [4:0]  quad_tab [15] = '{0, 29, 28, 27, 26, 26, 26, 27, 27, 28, 28, 30, 0, 5, 5};
  link_if lnk ();
  sensor_end #(.BIT_CYCLES(BIT)) sensor_end_inst (.clk, .rst, .link(lnk), .sealed_nv,
    .diag_flags, .field_value, .prog_mode, .app_mode, .seal_write,
    .linear_temp_coefficient_code(lin_code), .quadratic_temp_coefficient_code(quad_code));
  programmer_end #(.BIT_CYCLES(BIT)) programmer_end_inst (.clk, .rst, .link(lnk), .addr,
    .wdata, .wr, .rd, .rdata, .irq);
  link_sva #(.BIT_CYCLES(BIT)) link_sva_inst (.clk, .rst, .supply_line(lnk.supply_line),
    .out_line(lnk.out_line), .prog_mode, .app_mode, .sealed_nv);
  always #5 clk = ~clk;

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic lv(input bit o);
    return o ? lnk.out_line : lnk.supply_line;
  endfunction
  // decodes one frame off a wire: a change between the quarter points marks a one
  task automatic decode(input bit o, output logic [15:0] w);
    logic l0;
    int   n;
    l0 = lv(o);
    n = 0;
    while (lv(o) === l0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT / 4) @(posedge clk);
    for (int k = 15; k >= 0; k--) begin
      l0 = lv(o);
      repeat (BIT / 2) @(posedge clk);
      w[k] = lv(o) !== l0;
      repeat (BIT / 2) @(posedge clk);
    end
  endtask
  task automatic cmd(input logic [15:0] w, input logic [15:0] e, input logic dup);
    logic [15:0] w0, w1, st;
    fork
      decode(1'b0, w0);
      decode(1'b1, w1);
      begin
        wr_reg(`HOST_CMD, w);
        if (dup) begin
          wr_reg(`HOST_CMD, 16'h0500);
          rd_reg(`HOST_STATUS, st);
          chk(st, 16'h0001);
        end
      end
    join
    repeat (BIT) @(posedge clk);
    chk(w0, w);
    chk(w1, e);
    rd_reg(`HOST_REPLY, st);
    chk(st, e);
  endtask

  initial begin
    rst = 1'b1;
    sealed_nv = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    diag_flags = 8'h00;
    field_value = 8'ha5;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // mode is chosen four cycles after release
    repeat (6) @(posedge clk);
    chk({14'h0, prog_mode, app_mode}, 16'h0002);
    chk({3'h0, lin_code, 3'h0, quad_code}, 16'h151b);
    wr_reg(`HOST_MASK, 16'h0007);
    wr_reg(4'h9, 16'h0000);
    rd_reg(4'h9, got);
    chk(got, 16'h0000);
    rd_reg(`HOST_MASK, got);
    chk(got, 16'h0007);
    cmd(16'h0400, 16'h84a5, 1'b1);
    chk({15'h0, irq}, 16'h0001);
    rd_reg(`HOST_INT, got);
    chk(got, 16'h0003);
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    // a set diagnostic bit must show, or the zero check could never fail
    diag_flags <= 8'h3c;
    cmd(16'h0100, 16'h813c, 1'b0);
    diag_flags <= 8'h00;
    cmd(16'h0100, 16'h8100, 1'b0);
    // an invalid opcode gets no answer but counts as an error
    wr_reg(`HOST_CMD, 16'hc000);
    repeat (20 * BIT) @(posedge clk);
    cmd(16'h0500, 16'h8501, 1'b0);
    for (int i = 0; i < 15; i++) begin
      cmd({11'h210, lin_tab[i]}, {11'h410, lin_tab[i]}, 1'b0);
      cmd({11'h218, quad_tab[i]}, {11'h418, quad_tab[i]}, 1'b0);
      chk({3'h0, lin_code, 3'h0, quad_code}, {3'h0, lin_tab[i], 3'h0, quad_tab[i]});
    end
    rd_reg(`HOST_INT, got);
    wr_reg(`HOST_MASK, 16'h0000);
    cmd(16'h4002, 16'h8002, 1'b0);
    chk({13'h0, irq, seal_write, prog_mode}, 16'h0003);
    cmd(16'h0000, 16'h8002, 1'b0);
    rd_reg(`HOST_INT, got);
    chk(got, 16'h0003);
    cmd(16'h4001, 16'h8001, 1'b0);
    chk({14'h0, prog_mode, app_mode}, 16'h0001);
    rd_reg(`HOST_INT, got);
    // in application mode a command goes out but no answer comes back
    wr_reg(`HOST_CMD, 16'h0400);
    repeat (20 * BIT) @(posedge clk);
    rd_reg(`HOST_INT, got);
    chk(got, 16'h0001);
    @(posedge clk);
    rst <= 1'b1;
    sealed_nv <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk({14'h0, prog_mode, app_mode}, 16'h0001);
    print_verdict();
  end
endmodule // testbench
